// ===== calrtc_map.svh
// constants of the calendar clock: selects, field positions, reset values, timing
`ifndef CALRTC_MAP_SVH
`define CALRTC_MAP_SVH
`define CALRTC_BASE_YEAR 2112
`define CALRTC_REF_HZ 100000000
`define CALRTC_OSC_HZ 32768
`define CALRTC_PWRON_LOCK_S 15
`define CALRTC_UNLOCK_LOCK_S 2
`define CALRTC_DST_HOUR 5'h02
`define CALRTC_SEL_CTRL 4'h0
`define CALRTC_SEL_YM 4'h1
`define CALRTC_SEL_DAY 4'h2
`define CALRTC_SEL_HM 4'h3
`define CALRTC_SEL_SEC 4'h4
`define CALRTC_SEL_ALHM 4'h5
`define CALRTC_SEL_ALSEC 4'h6
`define CALRTC_SEL_CDN 4'h7
`define CALRTC_SEL_STAT 4'h8
`define CALRTC_CTL_UNLOCK 1:0
`define CALRTC_CTL_SWCLR 2
`define CALRTC_CTL_BCD 3
`define CALRTC_CTL_DSTOFF 4
`define CALRTC_CTL_CKEN 5
`define CALRTC_CTL_CKSEL 7:6
`define CALRTC_CTL_TAMP 11:8
`define CALRTC_UL_STEP0 2'h0
`define CALRTC_UL_STEP1 2'h1
`define CALRTC_UL_STEP2 2'h3
`define CALRTC_UL_LAST 2'h2
`define CALRTC_SEC_MAX 6'h3b
`define CALRTC_MIN_MAX 6'h3b
`define CALRTC_HOUR_MAX 5'h17
`define CALRTC_MON_MAX 4'hc
`define CALRTC_RST_MON 4'h1
`define CALRTC_RST_DAY 5'h01
`define CALRTC_RST_YEAR 8'h00
`define CALRTC_ST_ALARM 0
`define CALRTC_ST_CDN 1
`define CALRTC_ST_TAMP 2
`endif

// ===== calrtc_pkg.sv
// types of the calendar clock
`default_nettype none
package calrtc_pkg;
   typedef enum logic [2:0] {
      LK_LOCKED = 3'h0,
      LK_STEP1 = 3'h1,
      LK_STEP2 = 3'h3,
      LK_STEP3 = 3'h2,
      LK_OPEN = 3'h6
   } calrtc_lock_type;
   typedef enum logic [1:0] {
      CK_NONE = 2'h0,
      CK_ONE_HZ = 2'h1,
      CK_OSC = 2'h2
   } calrtc_clksel_type;
endpackage
`default_nettype wire

// ===== calrtc_tick_if.sv
// ticks and tamper result passed from the timebase to the calendar core
`timescale 1ns/1ps
`default_nettype none
interface calrtc_tick_if;
   logic osc_en;
   logic sec_en;
   logic osc_level;
   logic hz_level;
   logic tamper_hit;
   logic [3:0] tamper_filter;
   modport src(output osc_en, sec_en, osc_level, hz_level, tamper_hit, input tamper_filter);
   modport snk(input osc_en, sec_en, osc_level, hz_level, tamper_hit, output tamper_filter);
endinterface
`default_nettype wire

// ===== calrtc_tick.sv
// timebase from ref_clk: 32 kHz enables, 1 Hz enable, tamper filter
`timescale 1ns/1ps
`default_nettype none
`include "calrtc_map.svh"
module calrtc_tick #(
   parameter int OSC_PER_SEC = `CALRTC_OSC_HZ
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic tamper_pin,
   calrtc_tick_if.src tk
);
   localparam logic [27:0] REF_HZ = 28'(`CALRTC_REF_HZ);
   localparam logic [27:0] HALF_INC = 28'(2 * `CALRTC_OSC_HZ);
   localparam logic [15:0] LAST = 16'(OSC_PER_SEC - 1);
   localparam logic [15:0] HALF = 16'(OSC_PER_SEC / 2);
   logic [27:0] acc;
   logic [15:0] cnt;
   logic [3:0] fcnt;
   logic sync1, sync2, taken;
   wire [27:0] sum = acc + HALF_INC;
   wire half_tick = sum >= REF_HZ;
   wire osc_tick = half_tick && tk.osc_level;
   wire fmatch = (tk.tamper_filter == 4'h0) || (tk.osc_en && (fcnt + 4'h1 == tk.tamper_filter));
   // fractional divider, exact on average
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         acc <= 28'h0;
         tk.osc_level <= 1'b0;
      end else begin
         acc <= half_tick ? sum - REF_HZ : sum;
         if (half_tick) tk.osc_level <= !tk.osc_level;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         cnt <= 16'h0;
         tk.osc_en <= 1'b0;
         tk.sec_en <= 1'b0;
         tk.hz_level <= 1'b0;
      end else begin
         tk.osc_en <= osc_tick;
         tk.sec_en <= osc_tick && cnt == LAST;
         if (osc_tick) cnt <= (cnt == LAST) ? 16'h0 : cnt + 16'h1;
         tk.hz_level <= cnt < HALF;
      end
   end
   // tamper level accepted after the filter count of oscillator clocks
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         sync1 <= 1'b0;
         sync2 <= 1'b0;
         fcnt <= 4'h0;
         taken <= 1'b0;
         tk.tamper_hit <= 1'b0;
      end else begin
         sync1 <= tamper_pin;
         sync2 <= sync1;
         tk.tamper_hit <= 1'b0;
         if (!sync2) begin
            fcnt <= 4'h0;
            taken <= 1'b0;
         end else if (!taken && fmatch) begin
            tk.tamper_hit <= 1'b1;
            taken <= 1'b1;
         end else if (!taken && tk.osc_en) begin
            fcnt <= fcnt + 4'h1;
         end
      end
   end
   a_tamp_nofilt: assert property (@(posedge ref_clk) disable iff (!resetn)
      (tk.tamper_filter == 4'h0 && sync2 && !taken) |=> tk.tamper_hit)
      else $error("unfiltered tamper not accepted");
   a_tamp_wait: assert property (@(posedge ref_clk) disable iff (!resetn)
      (tk.tamper_hit && tk.tamper_filter != 4'h0) |-> $past(fcnt) + 4'h1 == tk.tamper_filter)
      else $error("tamper accepted before filter count");
endmodule // calrtc_tick
`default_nettype wire

// ===== calrtc_core.sv
// calendar real-time clock: counters, write lock, controls, clock output
`timescale 1ns/1ps
`default_nettype none
`include "calrtc_map.svh"
// How it works
// - year is a signed offset from base year 2112
// - clock output enable gates the selected clock onto clk_out
// - select 0 gives nothing, 1 the 1 Hz tick, 2 the oscillator clock
// - daylight-saving bit 0 enables automatic adjustment, 1 disables it
// - soft clear bit set clears alarm registers and status flags
// - bcd mode converts time, day and month reads and writes to BCD, year stays binary
// - tamper accepted after filter count of 32 kHz clocks, 0 means at once
// - month runs 1 to 12
// - day runs 1 to 31, bounded by month length
// - hour runs 0 to 23
// - minute runs 0 to 59
// - seconds run 0 to 59, writable alone when unlocked
// - year and month share a register, hour and minute share one
// - countdown value is readable at any time
// - code 10 written while open locks the registers again
// - open after reset, locks by itself after 15 seconds
// - after an unlock, locks by itself two seconds later
module calrtc_core #(
   parameter int OSC_PER_SEC = `CALRTC_OSC_HZ
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic wr_en,
   input wire logic [3:0] wr_sel,
   input wire logic [15:0] wr_data,
   input wire logic tamper_pin,
   input wire logic [3:0] dst_start_month,
   input wire logic [4:0] dst_start_day,
   input wire logic [3:0] dst_end_month,
   input wire logic [4:0] dst_end_day,
   output logic [15:0] year_month_reg,
   output logic [7:0] day_count_reg,
   output logic [15:0] hour_minute_reg,
   output logic [7:0] seconds_reg,
   output logic [7:0] countdown_reg,
   output logic [15:0] alarm_hm_reg,
   output logic [7:0] alarm_sec_reg,
   output logic [15:0] ctrl_reg,
   output logic [2:0] status_reg,
   output logic unlocked,
   output logic clk_out
);
   localparam logic [3:0] PWRON_TICKS = 4'(`CALRTC_PWRON_LOCK_S * 1);
   localparam logic [3:0] UNLOCK_TICKS = 4'(`CALRTC_UNLOCK_LOCK_S * 1);
   calrtc_tick_if tk();
   calrtc_pkg::calrtc_lock_type lock, next_lock;
   logic [3:0] lock_timer;
   logic [5:0] sec, min;
   logic [4:0] hour, day;
   logic [3:0] mon;
   logic signed [7:0] year;
   logic [7:0] cdn;
   logic [4:0] al_hour;
   logic [5:0] al_min, al_sec;
   logic [2:0] status;
   logic bcd, dst_off, ck_en, dst_done;
   logic [1:0] ck_sel;
   logic [3:0] tamp_ftr;

   function automatic logic is_leap(input logic signed [7:0] off);
      logic [11:0] y;
      y = 12'(`CALRTC_BASE_YEAR + off);
      return (y % 12'h004 == 12'h000) && ((y % 12'h064 != 12'h000) || (y % 12'h190 == 12'h000));
   endfunction
   function automatic logic [4:0] month_days(input logic [3:0] m, input logic signed [7:0] off);
      case (m)
         4'h2: month_days = is_leap(off) ? 5'h1d : 5'h1c;
         4'h4, 4'h6, 4'h9, 4'hb: month_days = 5'h1e;
         default: month_days = 5'h1f;
      endcase
   endfunction
   function automatic logic [6:0] conv_in(input logic [7:0] raw, input logic use_bcd);
      conv_in = use_bcd ? {3'h0, raw[7:4]} * 7'h0a + {3'h0, raw[3:0]} : raw[6:0];
   endfunction
   function automatic logic [7:0] conv_out(input logic [6:0] v, input logic use_bcd);
      conv_out = use_bcd ? {4'(v / 7'h0a), 4'(v % 7'h0a)} : {1'b0, v};
   endfunction

   calrtc_tick #(.OSC_PER_SEC(OSC_PER_SEC)) u_tick (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .tamper_pin(tamper_pin),
      .tk(tk.src)
   );
   assign tk.tamper_filter = tamp_ftr;

   // write decoding
   wire is_open = lock == calrtc_pkg::LK_OPEN;
   wire [1:0] code = wr_data[`CALRTC_CTL_UNLOCK];
   wire ctrl_wr = wr_en && wr_sel == `CALRTC_SEL_CTRL;
   wire ok = wr_en && is_open;
   wire w_ctrl = ok && wr_sel == `CALRTC_SEL_CTRL;
   wire w_ym = ok && wr_sel == `CALRTC_SEL_YM;
   wire w_day = ok && wr_sel == `CALRTC_SEL_DAY;
   wire w_hm = ok && wr_sel == `CALRTC_SEL_HM;
   wire w_sec = ok && wr_sel == `CALRTC_SEL_SEC;
   wire w_alhm = ok && wr_sel == `CALRTC_SEL_ALHM;
   wire w_alsec = ok && wr_sel == `CALRTC_SEL_ALSEC;
   wire w_cdn = ok && wr_sel == `CALRTC_SEL_CDN;
   wire w_stat = wr_en && wr_sel == `CALRTC_SEL_STAT;
   wire soft_clr = w_ctrl && wr_data[`CALRTC_CTL_SWCLR];
   wire [6:0] in_lo = conv_in(wr_data[7:0], bcd);
   wire [6:0] in_hi = conv_in(wr_data[15:8], bcd);

   // calendar cascade
   wire [4:0] dim = month_days(mon, year);
   wire min_step = tk.sec_en && sec == `CALRTC_SEC_MAX;
   wire hour_step = min_step && min == `CALRTC_MIN_MAX;
   wire day_step = hour_step && hour == `CALRTC_HOUR_MAX;
   wire mon_step = day_step && day == dim;
   wire year_step = mon_step && mon == `CALRTC_MON_MAX;
   wire dst_hour = hour == `CALRTC_DST_HOUR - 5'h01;
   wire dst_fwd = !dst_off && hour_step && dst_hour && mon == dst_start_month
      && day == dst_start_day;
   wire dst_back = !dst_off && hour_step && dst_hour && mon == dst_end_month
      && day == dst_end_day && !dst_done;
   wire [5:0] next_sec = w_sec ? in_lo[5:0] : !tk.sec_en ? sec
      : (sec == `CALRTC_SEC_MAX) ? 6'h00 : sec + 6'h01;
   wire [5:0] next_min = w_hm ? in_lo[5:0] : !min_step ? min
      : (min == `CALRTC_MIN_MAX) ? 6'h00 : min + 6'h01;
   wire [4:0] next_hour = w_hm ? in_hi[4:0] : !hour_step ? hour
      : dst_fwd ? `CALRTC_DST_HOUR + 5'h01 : dst_back ? hour
      : (hour == `CALRTC_HOUR_MAX) ? 5'h00 : hour + 5'h01;
   wire [4:0] next_day = w_day ? in_lo[4:0] : !day_step ? day
      : (day == dim) ? 5'h01 : day + 5'h01;
   wire [3:0] next_mon = w_ym ? in_lo[3:0] : !mon_step ? mon
      : (mon == `CALRTC_MON_MAX) ? 4'h1 : mon + 4'h1;
   wire signed [7:0] next_year = w_ym ? wr_data[15:8] : year_step ? year + 8'sh01 : year;
   wire cdn_step = min_step && cdn != 8'h00 && !w_cdn;
   wire alarm_hit = tk.sec_en && {next_hour, next_min, next_sec} == {al_hour, al_min, al_sec};
   wire [2:0] st_set = {tk.tamper_hit, cdn_step && cdn == 8'h01, alarm_hit};
   wire [2:0] st_clr = soft_clr ? 3'h7 : w_stat ? wr_data[2:0] : 3'h0;
   wire clk_sel_out = (ck_sel == calrtc_pkg::CK_ONE_HZ) ? tk.hz_level
      : (ck_sel == calrtc_pkg::CK_OSC) ? tk.osc_level : 1'b0;

   // unlock sequence
   always_comb begin
      next_lock = lock;
      unique case (lock)
         calrtc_pkg::LK_OPEN:
            if ((ctrl_wr && code == `CALRTC_UL_LAST)
               || (tk.sec_en && lock_timer == 4'h1)) next_lock = calrtc_pkg::LK_LOCKED;
         calrtc_pkg::LK_LOCKED:
            if (ctrl_wr && code == `CALRTC_UL_STEP0) next_lock = calrtc_pkg::LK_STEP1;
         calrtc_pkg::LK_STEP1:
            if (ctrl_wr) next_lock = (code == `CALRTC_UL_STEP1) ? calrtc_pkg::LK_STEP2
               : (code == `CALRTC_UL_STEP0) ? calrtc_pkg::LK_STEP1 : calrtc_pkg::LK_LOCKED;
         calrtc_pkg::LK_STEP2:
            if (ctrl_wr) next_lock = (code == `CALRTC_UL_STEP2) ? calrtc_pkg::LK_STEP3
               : (code == `CALRTC_UL_STEP0) ? calrtc_pkg::LK_STEP1 : calrtc_pkg::LK_LOCKED;
         calrtc_pkg::LK_STEP3:
            if (ctrl_wr) next_lock = (code == `CALRTC_UL_LAST) ? calrtc_pkg::LK_OPEN
               : (code == `CALRTC_UL_STEP0) ? calrtc_pkg::LK_STEP1 : calrtc_pkg::LK_LOCKED;
         default:
            next_lock = calrtc_pkg::LK_LOCKED;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         lock <= calrtc_pkg::LK_OPEN;
         lock_timer <= PWRON_TICKS;
      end else begin
         lock <= next_lock;
         if (next_lock == calrtc_pkg::LK_OPEN && lock != calrtc_pkg::LK_OPEN)
            lock_timer <= UNLOCK_TICKS;
         else if (is_open && tk.sec_en && lock_timer != 4'h0)
            lock_timer <= lock_timer - 4'h1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         sec <= 6'h00;
         min <= 6'h00;
         hour <= 5'h00;
         day <= `CALRTC_RST_DAY;
         mon <= `CALRTC_RST_MON;
         year <= `CALRTC_RST_YEAR;
         dst_done <= 1'b0;
      end else begin
         sec <= next_sec;
         min <= next_min;
         hour <= next_hour;
         day <= next_day;
         mon <= next_mon;
         year <= next_year;
         if (day_step) dst_done <= 1'b0;
         else if (dst_back) dst_done <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         cdn <= 8'h00;
         al_hour <= 5'h00;
         al_min <= 6'h00;
         al_sec <= 6'h00;
         status <= 3'h0;
      end else begin
         if (w_cdn) cdn <= wr_data[7:0];
         else if (cdn_step) cdn <= cdn - 8'h01;
         if (soft_clr) begin
            al_hour <= 5'h00;
            al_min <= 6'h00;
            al_sec <= 6'h00;
         end else begin
            if (w_alhm) al_hour <= in_hi[4:0];
            if (w_alhm) al_min <= in_lo[5:0];
            if (w_alsec) al_sec <= in_lo[5:0];
         end
         status <= (status & ~st_clr) | st_set;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         bcd <= 1'b0;
         dst_off <= 1'b0;
         ck_en <= 1'b0;
         ck_sel <= calrtc_pkg::CK_NONE;
         tamp_ftr <= 4'h0;
      end else if (w_ctrl) begin
         bcd <= wr_data[`CALRTC_CTL_BCD];
         dst_off <= wr_data[`CALRTC_CTL_DSTOFF];
         ck_en <= wr_data[`CALRTC_CTL_CKEN];
         ck_sel <= wr_data[`CALRTC_CTL_CKSEL];
         tamp_ftr <= wr_data[`CALRTC_CTL_TAMP];
      end
   end

   // registered read views
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         year_month_reg <= 16'h0000;
         day_count_reg <= 8'h00;
         hour_minute_reg <= 16'h0000;
         seconds_reg <= 8'h00;
         countdown_reg <= 8'h00;
         alarm_hm_reg <= 16'h0000;
         alarm_sec_reg <= 8'h00;
         ctrl_reg <= 16'h0000;
         status_reg <= 3'h0;
         unlocked <= 1'b0;
         clk_out <= 1'b0;
      end else begin
         year_month_reg <= {year, conv_out({3'h0, mon}, bcd)};
         day_count_reg <= conv_out({2'h0, day}, bcd);
         hour_minute_reg <= {conv_out({2'h0, hour}, bcd), conv_out({1'b0, min}, bcd)};
         seconds_reg <= conv_out({1'b0, sec}, bcd);
         countdown_reg <= cdn;
         alarm_hm_reg <= {conv_out({2'h0, al_hour}, bcd), conv_out({1'b0, al_min}, bcd)};
         alarm_sec_reg <= conv_out({1'b0, al_sec}, bcd);
         ctrl_reg <= {4'h0, tamp_ftr, ck_sel, ck_en, dst_off, bcd, 3'h0};
         status_reg <= status;
         unlocked <= is_open;
         clk_out <= ck_en && clk_sel_out;
      end
   end

   wire quiet = !ok;
   sequence s_last_step;
      lock == calrtc_pkg::LK_STEP3 && ctrl_wr && code == `CALRTC_UL_LAST;
   endsequence
   sequence s_two_then_open;
      is_open [*2];
   endsequence
   a_unlock_seq: assert property (@(posedge ref_clk) disable iff (!resetn)
      s_last_step |=> s_two_then_open ##1 unlocked)
      else $error("unlock sequence did not open");
   a_relock_now: assert property (@(posedge ref_clk) disable iff (!resetn)
      (is_open && ctrl_wr && code == `CALRTC_UL_LAST) |=> !is_open ##1 !unlocked)
      else $error("code 10 did not lock");
   a_auto_lock: assert property (@(posedge ref_clk) disable iff (!resetn)
      (is_open && tk.sec_en && lock_timer == 4'h1) |=> lock == calrtc_pkg::LK_LOCKED)
      else $error("lock timer expired without locking");
   a_unlock_time: assert property (@(posedge ref_clk) disable iff (!resetn)
      s_last_step |=> lock_timer == UNLOCK_TICKS)
      else $error("unlock did not load two second timer");
   a_locked_block: assert property (@(posedge ref_clk) disable iff (!resetn)
      (!is_open && wr_en && wr_sel == `CALRTC_SEL_DAY && !tk.sec_en) |=> $stable(day))
      else $error("day written while locked");
   a_sec_wrap: assert property (@(posedge ref_clk) disable iff (!resetn)
      (min_step && quiet && min != `CALRTC_MIN_MAX) |=> sec == 6'h00
      && min == $past(min) + 6'h01)
      else $error("seconds rollover did not carry");
   a_hour_wrap: assert property (@(posedge ref_clk) disable iff (!resetn)
      (day_step && quiet) |=> hour == 5'h00 && min == 6'h00)
      else $error("hour did not wrap at 23");
   a_month_wrap: assert property (@(posedge ref_clk) disable iff (!resetn)
      (year_step && quiet) |=> mon == 4'h1 && day == 5'h01 && year == $past(year) + 8'sh01)
      else $error("year did not advance after december");
   a_clk_gate: assert property (@(posedge ref_clk) disable iff (!resetn)
      !ck_en |=> !clk_out)
      else $error("clock output not suppressed");
   a_soft_clear: assert property (@(posedge ref_clk) disable iff (!resetn)
      soft_clr |=> al_hour == 5'h00 && al_min == 6'h00 && al_sec == 6'h00)
      else $error("soft clear left alarm set");
   a_dst_fwd: assert property (@(posedge ref_clk) disable iff (!resetn)
      (dst_fwd && quiet) |=> hour == `CALRTC_DST_HOUR + 5'h01)
      else $error("daylight saving step missed");
   a_cdn_read: assert property (@(posedge ref_clk) disable iff (!resetn)
      1'b1 |=> countdown_reg == $past(cdn))
      else $error("countdown readback stale");
endmodule // calrtc_core
`default_nettype wire

// ===== tb_top.sv
// self-checking bench of the calendar clock core
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   // cycles in one second: two oscillator enables of about 3052 cycles each
   localparam int SEC = 6104;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic wr_en = 1'b0;
   logic [3:0] wr_sel = 4'h0;
   logic [15:0] wr_data = 16'h0000;
   logic tamper_pin = 1'b0;
   logic [15:0] year_month_reg, hour_minute_reg, alarm_hm_reg, ctrl_reg;
   logic [7:0] day_count_reg, seconds_reg, countdown_reg, alarm_sec_reg;
   logic [2:0] status_reg;
   logic unlocked, clk_out;
   int errors = 0;
   int n_compared = 0;
   int cyc = 0;
   logic [31:0] rs = 32'hcde3;

   calrtc_core #(.OSC_PER_SEC(2)) i_calrtc_core (.ref_clk(ref_clk), .resetn(resetn),
      .wr_en(wr_en), .wr_sel(wr_sel), .wr_data(wr_data), .tamper_pin(tamper_pin),
      .dst_start_month(4'h3), .dst_start_day(5'h0a), .dst_end_month(4'hb),
      .dst_end_day(5'h03), .year_month_reg(year_month_reg), .day_count_reg(day_count_reg),
      .hour_minute_reg(hour_minute_reg), .seconds_reg(seconds_reg),
      .countdown_reg(countdown_reg), .alarm_hm_reg(alarm_hm_reg),
      .alarm_sec_reg(alarm_sec_reg), .ctrl_reg(ctrl_reg), .status_reg(status_reg),
      .unlocked(unlocked), .clk_out(clk_out));

   initial begin
      forever #5 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk) begin
      cyc <= resetn ? cyc + 1 : 0;
   end

   function automatic logic [31:0] rnd();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs;
   endfunction

   // f holds filter, select, enable, dst off, bcd from msb to lsb
   function automatic logic [15:0] ctl(input logic [1:0] unl, input logic sw,
                                       input logic [8:0] f);
      return {4'h0, f, sw, unl};
   endfunction

   function automatic logic [15:0] exp_ck(input logic [8:0] f);
      return (f[2] && (f[4:3] == 2'h1 || f[4:3] == 2'h2)) ? 16'h0003 : 16'h0001;
   endfunction

   task automatic final_report();
      if (errors == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, seen, exp);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   task automatic wr(input logic [3:0] sel, input logic [15:0] d);
      wr_en = 1'b1;
      wr_sel = sel;
      wr_data = d;
      step(1);
      wr_en = 1'b0;
      step(1);
   endtask

   task automatic set_time(input logic [15:0] ym, input logic [7:0] d,
                           input logic [15:0] hm, input logic [7:0] s);
      wr(4'h1, ym);
      wr(4'h2, {8'h00, d});
      wr(4'h3, hm);
      wr(4'h4, {8'h00, s});
   endtask

   task automatic tick();
      logic [7:0] s0;
      s0 = seconds_reg;
      for (int k = 0; k < 2 * SEC && seconds_reg === s0; k++) step(1);
      step(2);
   endtask

   task automatic unl();
      wr(4'h0, 16'h0000);
      wr(4'h0, 16'h0001);
      wr(4'h0, 16'h0003);
      wr(4'h0, 16'h0002);
   endtask

   initial begin
      repeat (17 * SEC + 4000) @(posedge ref_clk);
      errors++;
      final_report();
   end

   initial begin
      int n;
      logic [31:0] r;
      logic [8:0] f;
      logic hi, lo;
      repeat (8) @(posedge ref_clk);
      #1;
      resetn = 1'b1;
      step(3);
      chk(year_month_reg, 16'h0001, "reset date");
      chk({8'h00, day_count_reg}, 16'h0001, "reset day");
      chk(hour_minute_reg, 16'h0000, "reset time");
      chk({15'h0, unlocked}, 16'h0001, "open after reset");
      // year end carry through every counter, countdown hits zero
      wr(4'h7, 16'h0001);
      set_time(16'h9a0c, 8'h1f, 16'h173b, 8'h3b);
      tick();
      chk(year_month_reg, 16'h9b01, "year carry");
      chk({8'h00, day_count_reg}, 16'h0001, "day carry");
      chk(hour_minute_reg, 16'h0000, "hour carry");
      chk({8'h00, seconds_reg}, 16'h0000, "second carry");
      chk({8'h00, countdown_reg}, 16'h0000, "countdown");
      chk({15'h0, status_reg[1]}, 16'h0001, "countdown flag");
      chk({15'h0, status_reg[0]}, 16'h0001, "midnight alarm");
      set_time(16'h0003, 8'h0a, 16'h013b, 8'h3b);
      tick();
      chk(hour_minute_reg, 16'h0300, "dst on");
      set_time(16'h000b, 8'h03, 16'h013b, 8'h3b);
      tick();
      chk(hour_minute_reg, 16'h0100, "dst back");
      wr(4'h0, ctl(2'h0, 1'b0, 9'h002));
      set_time(16'h0003, 8'h0a, 16'h013b, 8'h3b);
      tick();
      chk(hour_minute_reg, 16'h0200, "dst off");
      wr(4'h0, ctl(2'h0, 1'b0, 9'h003));
      wr(4'h4, 16'h0049);
      tick();
      chk({8'h00, seconds_reg}, 16'h0050, "bcd seconds");
      // tamper with no filter, then with a count of two
      wr(4'h0, ctl(2'h0, 1'b0, 9'h002));
      wr(4'h8, 16'h0007);
      tamper_pin = 1'b1;
      step(10);
      chk({15'h0, status_reg[2]}, 16'h0001, "tamper unfiltered");
      tamper_pin = 1'b0;
      wr(4'h0, ctl(2'h0, 1'b0, 9'h042));
      wr(4'h8, 16'h0007);
      tamper_pin = 1'b1;
      step(200);
      chk({15'h0, status_reg[2]}, 16'h0000, "tamper early");
      for (n = 0; n < 7000 && status_reg[2] !== 1'b1; n++) step(1);
      chk({15'h0, status_reg[2]}, 16'h0001, "tamper late");
      tamper_pin = 1'b0;
      wr(4'h5, 16'h0a0b);
      wr(4'h6, 16'h000c);
      wr(4'h0, ctl(2'h0, 1'b0, 9'h002));
      chk(alarm_hm_reg, 16'h0a0b, "alarm kept");
      wr(4'h0, ctl(2'h0, 1'b1, 9'h002));
      chk(alarm_hm_reg, 16'h0000, "alarm cleared");
      chk({8'h00, alarm_sec_reg}, 16'h0000, "alarm sec cleared");
      chk({13'h0, status_reg}, 16'h0000, "flags cleared");
      // every clock select code, enable set except on the last pass, other control fields random
      for (int i = 0; i < 5; i++) begin
         r = rnd();
         f = r[8:0];
         f[4:3] = (i == 4) ? 2'h2 : i[1:0];
         f[2] = (i != 4);
         wr(4'h0, ctl(2'h0, 1'b0, f));
         chk(ctrl_reg, {4'h0, f, 3'h0}, "control readback");
         hi = 1'b0;
         lo = 1'b0;
         repeat (3500) begin
            step(1);
            hi = hi | (clk_out === 1'b1);
            lo = lo | (clk_out === 1'b0);
         end
         chk({14'h0, hi, lo}, exp_ck(f), "clock output");
      end
      wr(4'h0, ctl(2'h0, 1'b0, 9'h002));
      while (unlocked === 1'b1 && cyc < 17 * SEC) step(1);
      chk({15'h0, cyc > 14 * SEC && cyc < 16 * SEC}, 16'h0001, "power-on lock");
      wr(4'h1, 16'h1107);
      chk(year_month_reg, 16'h0003, "locked write");
      wr(4'h2, 16'h0005);
      chk({8'h00, day_count_reg}, 16'h000a, "locked day write");
      wr(4'h0, 16'h0000);
      wr(4'h0, 16'h0001);
      wr(4'h0, 16'h0002);
      chk({15'h0, unlocked}, 16'h0000, "short sequence");
      unl();
      step(1);
      chk({15'h0, unlocked}, 16'h0001, "unlock");
      wr(4'h1, 16'h0505);
      chk(year_month_reg, 16'h0505, "open write");
      wr(4'h0, 16'h0002);
      step(1);
      chk({15'h0, unlocked}, 16'h0000, "relock");
      wr(4'h1, 16'h0607);
      chk(year_month_reg, 16'h0505, "relocked write");
      unl();
      n = cyc;
      while (unlocked === 1'b1 && cyc - n < 4 * SEC) step(1);
      chk({15'h0, cyc - n > SEC * 9 / 10 && cyc - n < SEC * 23 / 10}, 16'h0001,
          "unlock expiry");
      final_report();
   end
endmodule // tb_top
`default_nettype wire
